// [common/ipsc_pkg.sv]
// shared constants and types for the image port stream coder
`default_nettype none
package ipsc_pkg;
	localparam logic [7:0] IDLE_BYTE = 8'h00;
	localparam logic [7:0] PRE_FF = 8'hFF;
	localparam logic [7:0] PRE_ZERO = 8'h00;
	localparam logic [7:0] FILL_BYTE = 8'hA0;
	localparam logic [5:0] DC_FIXED = 6'h0B;
	localparam logic [5:0] SEL_MSB_SET = 6'h3E;
	localparam logic [5:0] SEL_MSB_CLR = 6'h3F;
	localparam logic [5:0] ID_BYTES = 6'h02;
	localparam logic [5:0] MAX_TEXT = 6'h2A;
	localparam logic [5:0] DW_ROUND = 6'h03;
	localparam logic [8:0] LINE_FIRST = 9'h001;
	localparam logic [8:0] LINE_LAST_LOW = 9'h017;
	localparam logic [8:0] LINE_NEXT = 9'h018;
	localparam logic [1:0] PRE_LAST = 2'h2;
	localparam int BURST_W = 8;
	// timing code table, index {msb, v, h, field}
	localparam logic [15:0][7:0] VCODE = {
		8'hF1, 8'hB6, 8'hEC, 8'hAB, 8'hDA, 8'h9D, 8'hC7, 8'h80,
		8'h7F, 8'h38, 8'h62, 8'h25, 8'h54, 8'h13, 8'h49, 8'h0E};
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_HDR = 8'h04;
	localparam logic [7:0] ADDR_SRC = 8'h08;
	localparam logic [7:0] ADDR_MAP = 8'h0C;
	localparam logic [7:0] ADDR_POL = 8'h10;
	localparam logic [7:0] ADDR_STAT = 8'h14;
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000, ST_PRE = 4'b0001, ST_CODE = 4'b0010,
		ST_VID = 4'b0011, ST_DID = 4'b0100, ST_SOURCE_ID_BYTE = 4'b0101,
		ST_DC = 4'b0110, ST_ID1 = 4'b0111, ST_ID2 = 4'b1000,
		ST_DATA = 4'b1001, ST_CS = 4'b1010, ST_BC = 4'b1011
	} ipsc_state_enum_type;
	typedef enum logic [1:0] {
		K_VSAV = 2'b00, K_VEAV = 2'b01, K_TSAV = 2'b10, K_TEAV = 2'b11
	} ipsc_kind_type;
	typedef enum logic [2:0] {
		SRC_QUAL = 3'b000, SRC_HORIZONTAL_GATE = 3'b001, SRC_VREF = 3'b010,
		SRC_FIELD = 3'b011, SRC_SLICED = 3'b100, SRC_HOLD = 3'b101
	} ipsc_src_type;
	typedef struct packed {
		logic gate_en;
		logic page_b;
		logic page_a;
		logic trig;
		logic code_off;
	} ipsc_ctrl_type;
	typedef struct packed {
		ipsc_ctrl_type ctrl;
		logic [5:0] hdr_sel;
		logic [5:0] src_id;
		logic [14:0] map;
		logic [4:0] pol;
	} ipsc_cfg_type;
	localparam ipsc_cfg_type CFG_RESET = '{ctrl: 5'h00, hdr_sel: 6'h3E,
		src_id: 6'h00, map: 15'h3888, pol: 5'h00};
	typedef struct packed {
		logic [7:0] data;
		logic first;
		logic last;
		logic field_identifier;
		logic vblank;
		logic last_active;
		logic task_b;
	} ipsc_vid_type;
	typedef struct packed {
		logic [8:0] line;
		logic [3:0] dtype;
		logic [5:0] count;
		logic field_identifier;
		logic vblank;
	} ipsc_txt_type;
	typedef struct packed {
		ipsc_cfg_type cfg;
		ipsc_state_enum_type state;
		ipsc_kind_type kind;
		logic anc;
		logic [1:0] idx;
		logic [5:0] pos;
		logic [5:0] total;
		logic [5:0] nbytes;
		ipsc_txt_type txt;
		logic vf;
		logic vv;
		logic vmsb;
		logic [7:0] cs;
		logic [7:0] dout;
		logic qual;
		logic hgate;
		logic vgate;
		logic sliced;
		logic gs1;
		logic gs2;
		logic [BURST_W-1:0] burst;
		logic [31:0] rdata;
		logic [4:0] pins;
	} ipsc_reg_type;
endpackage
`default_nettype wire

// [logic/ipsc_coder.sv]
// image port byte stream coder with timing codes and sliced text packets
// Function
// R1: gates frame valid data while references active; optional rising-edge trigger pulses.
// R2: a data qualifier accompanies the stream; invalid cycles carry 00h.
// R3: timing codes and their preambles can be switched off entirely.
// R4: external hold gate pauses output; bursts then run a guaranteed length.
// R5: events map onto five output pins, each polarity programmable, default high.
// R6: before first pixel of active line emit 0E/49, or 80/C7 with MSB.
// R7: after last pixel of non-final active line emit 13/54 or 9D/DA.
// R8: before first pixel of blanking line emit 25/62 or AB/EC.
// R9: after final active or blanking line emit 38/7F or B6/F1.
// R10: no-data cycles carry 00 with qualifier low; receiver ignores them.
// R11: every timing code byte follows preamble FFh, 00h, 00h.
// R12: video MSB is inverted task page bit; select 3Eh sets, 3Fh clears.
// R13: source id byte: six programmable bits, even parity, inverted parity.
// R14: timing-code framing fixes double word count byte at 4Bh.
// R15: ancillary count is quarter of two id bytes plus text bytes.
// R16: id bytes carry odd parity, field, line number and data type.
// R17: timing-code framing pads unused data bytes with A0h.
// R18: checksum sums header byte through last data byte.
// R19: valid byte count: six count bits, bit 6 zero, odd parity.
// R20: bit 6 even parity of bits 5..0, bit 7 inverse or odd parity.
// R21: identifier carries field and two-bit line region code.
// R22: sliced timing code: field, blanking flag, line-end flag, protection bits.
// R23: select below 3Eh gives ancillary header; 3Eh and 3Fh timing codes.
// R24: sliced flag rises with first header byte, falls at video start code.
// R25: protection bits follow the usual Hamming scheme of timing codes.
//
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module ipsc_coder import ipsc_pkg::*; #(
	parameter logic [BURST_W-1:0] BURST_LEN = 8'h10
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic vid_valid,
	input wire ipsc_vid_type vid_in,
	output logic vid_ready,
	input wire logic txt_req,
	input wire ipsc_txt_type txt_info,
	output logic txt_ack,
	input wire logic txt_valid,
	input wire logic [7:0] txt_data,
	output logic txt_ready,
	input wire logic output_hold_gate_input,
	output logic [7:0] port_data,
	output logic output_data_qualifier_pin,
	output logic horizontal_reference_pin,
	output logic vertical_reference_pin,
	output logic general_output_pin_a,
	output logic general_output_pin_b
);
	ipsc_reg_type st_reg;
	ipsc_reg_type st_next;
	logic adv;
	logic [5:0] text_lim;
	logic [7:0] code_byte;
	logic [7:0] out_byte;
	logic emit;
	logic [5:0] src_vec;
	logic hsrc;
	logic vsrc;

	// R20: header byte with even parity and its inverse
	function automatic logic [7:0] pbyte(input logic [5:0] x);
		pbyte = {~(^x), ^x, x};
	endfunction

	// R20: odd parity over seven bits
	function automatic logic oddp(input logic [6:0] x);
		oddp = ~(^x);
	endfunction

	// R25: hamming protection of field, blanking, line-end flags
	function automatic logic [3:0] prot(input logic f, input logic v,
		input logic h);
		prot = {v ^ h, f ^ h, f ^ v, f ^ v ^ h};
	endfunction

	// R21: line region from line number
	function automatic logic [1:0] region(input logic [8:0] ln);
		if (ln < LINE_FIRST) begin
			region = 2'h0;
		end else if (ln <= LINE_LAST_LOW) begin
			region = 2'h1;
		end else if (ln == LINE_NEXT) begin
			region = 2'h2;
		end else begin
			region = 2'h3;
		end
	endfunction

	// R15: double words for id bytes plus text bytes, rounded up
	function automatic logic [5:0] dwords(input logic [5:0] n);
		dwords = 6'((ID_BYTES + n + DW_ROUND) >> 2);
	endfunction

	// R4: hold gate, with a burst running out once started
	assign adv = !st_reg.cfg.ctrl.gate_en || st_reg.gs2 ||
		(st_reg.burst != '0);
	assign text_lim = ID_BYTES + st_reg.nbytes;
	assign vid_ready = (st_reg.state == ST_VID) && adv;
	assign txt_ack = (st_reg.state == ST_IDLE) && txt_req && !vid_valid &&
		adv;
	assign txt_ready = (st_reg.state == ST_DATA) && adv &&
		(st_reg.pos < text_lim);

	// R6: R7: R8: R9: R12: R22: timing code byte selection
	always_comb begin
		if (!st_reg.kind[1]) begin
			code_byte = VCODE[{st_reg.vmsb, st_reg.vv, st_reg.kind[0],
				st_reg.vf}];
		end else begin
			code_byte = {st_reg.cfg.hdr_sel == SEL_MSB_SET, st_reg.txt.field_identifier,
				st_reg.txt.vblank, st_reg.kind[0],
				prot(st_reg.txt.field_identifier, st_reg.txt.vblank, st_reg.kind[0])};
		end
	end

	always_comb begin
		st_next = st_reg;
		out_byte = IDLE_BYTE;
		emit = 1'b0;
		st_next.rdata = '0;
		st_next.gs1 = output_hold_gate_input;
		st_next.gs2 = st_reg.gs1;
		if (st_reg.cfg.ctrl.gate_en) begin
			if (st_reg.burst != '0) begin
				st_next.burst = st_reg.burst - 1'b1;
			end else if (st_reg.gs2) begin
				st_next.burst = BURST_LEN - 1'b1;
			end
		end else begin
			st_next.burst = '0;
		end
		// register port
		if (reg_wr) begin
			if (reg_addr == ADDR_CTRL) begin
				st_next.cfg.ctrl = reg_wdata[$bits(ipsc_ctrl_type)-1:0];
			end else if (reg_addr == ADDR_HDR) begin
				st_next.cfg.hdr_sel = reg_wdata[5:0];
			end else if (reg_addr == ADDR_SRC) begin
				st_next.cfg.src_id = reg_wdata[5:0];
			end else if (reg_addr == ADDR_MAP) begin
				st_next.cfg.map = reg_wdata[14:0];
			end else if (reg_addr == ADDR_POL) begin
				st_next.cfg.pol = reg_wdata[4:0];
			end
		end
		if (reg_rd) begin
			if (reg_addr == ADDR_CTRL) begin
				st_next.rdata = 32'(st_reg.cfg.ctrl);
			end else if (reg_addr == ADDR_HDR) begin
				st_next.rdata = 32'(st_reg.cfg.hdr_sel);
			end else if (reg_addr == ADDR_SRC) begin
				st_next.rdata = 32'(st_reg.cfg.src_id);
			end else if (reg_addr == ADDR_MAP) begin
				st_next.rdata = 32'(st_reg.cfg.map);
			end else if (reg_addr == ADDR_POL) begin
				st_next.rdata = 32'(st_reg.cfg.pol);
			end else if (reg_addr == ADDR_STAT) begin
				st_next.rdata = 32'({st_reg.gs2, st_reg.vf, st_reg.sliced,
					st_reg.state});
			end
		end
		// stream sequencer, moves only when the hold gate allows
		if (adv) begin
			case (st_reg.state)
				ST_IDLE: begin
					// R1: gate closes once the line is over
					st_next.hgate = 1'b0;
					if (vid_valid) begin
						st_next.vf = vid_in.field_identifier;
						st_next.vv = vid_in.vblank;
						// R12: video msb from inverted page bit
						st_next.vmsb = vid_in.task_b ? !st_reg.cfg.ctrl.page_b :
							!st_reg.cfg.ctrl.page_a;
						st_next.kind = K_VSAV;
						st_next.anc = 1'b0;
						st_next.idx = '0;
						// R3: skip codes when switched off
						if (vid_in.first && !st_reg.cfg.ctrl.code_off) begin
							st_next.state = ST_PRE;
						end else begin
							st_next.state = ST_VID;
							st_next.hgate = 1'b1;
							st_next.vgate = !vid_in.vblank;
							st_next.sliced = 1'b0;
						end
					end else if (txt_req) begin
						st_next.txt = txt_info;
						st_next.nbytes = (txt_info.count > MAX_TEXT) ? MAX_TEXT :
							txt_info.count;
						// R23: header kind from select value
						st_next.anc = st_reg.cfg.hdr_sel < SEL_MSB_SET;
						st_next.kind = K_TSAV;
						st_next.idx = '0;
						st_next.cs = '0;
						if (!st_reg.cfg.ctrl.code_off) begin
							st_next.state = ST_PRE;
						end else if (st_reg.cfg.hdr_sel < SEL_MSB_SET) begin
							st_next.state = ST_DID;
						end else begin
							st_next.state = ST_SOURCE_ID_BYTE;
						end
					end
				end
				ST_PRE: begin
					// R11: preamble ahead of each code byte
					emit = 1'b1;
					st_next.hgate = 1'b0;
					if (st_reg.anc) begin
						out_byte = (st_reg.idx == '0) ? PRE_ZERO : PRE_FF;
					end else begin
						out_byte = (st_reg.idx == '0) ? PRE_FF : PRE_ZERO;
					end
					// R24: sliced flag rises with first header byte
					if (st_reg.kind == K_TSAV) begin
						st_next.sliced = 1'b1;
					end
					st_next.idx = st_reg.idx + 1'b1;
					if (st_reg.idx == PRE_LAST) begin
						st_next.idx = '0;
						st_next.state = st_reg.anc ? ST_DID : ST_CODE;
					end
				end
				ST_CODE: begin
					emit = 1'b1;
					out_byte = code_byte;
					case (st_reg.kind)
						K_VSAV: begin
							st_next.state = ST_VID;
							// R1: gates open with the line
							st_next.hgate = 1'b1;
							st_next.vgate = !st_reg.vv;
							// R24: video start code ends the sliced period
							st_next.sliced = 1'b0;
						end
						K_TSAV: begin
							// R18: sum starts at the start code
							st_next.cs = code_byte;
							st_next.state = ST_SOURCE_ID_BYTE;
						end
						default: begin
							st_next.state = ST_IDLE;
						end
					endcase
				end
				ST_VID: begin
					if (vid_valid) begin
						emit = 1'b1;
						out_byte = vid_in.data;
						if (vid_in.last) begin
							st_next.vv = vid_in.vblank || vid_in.last_active;
							st_next.vf = vid_in.field_identifier;
							st_next.kind = K_VEAV;
							st_next.state = st_reg.cfg.ctrl.code_off ? ST_IDLE :
								ST_PRE;
						end
					end
				end
				ST_DID: begin
					// R21: identifier with field and line region for select 0, else from select bits 4..0 with bit 5 zero
					emit = 1'b1;
					if (st_reg.cfg.hdr_sel == '0) begin
						out_byte = pbyte({3'h2, st_reg.txt.field_identifier,
							region(st_reg.txt.line)});
					end else if (st_reg.cfg.hdr_sel[5]) begin
						out_byte = pbyte({1'b0, st_reg.cfg.hdr_sel[4:0]});
					end else begin
						out_byte = pbyte(st_reg.cfg.hdr_sel);
					end
					st_next.sliced = 1'b1;
					st_next.cs = out_byte;
					st_next.state = ST_SOURCE_ID_BYTE;
				end
				ST_SOURCE_ID_BYTE: begin
					// R13: programmable source id with parity pair
					emit = 1'b1;
					out_byte = pbyte(st_reg.cfg.src_id);
					st_next.sliced = 1'b1;
					st_next.cs = st_reg.cs + out_byte;
					st_next.state = ST_DC;
				end
				ST_DC: begin
					emit = 1'b1;
					// R14: R15: fixed or computed double word count
					if (st_reg.anc) begin
						out_byte = pbyte(dwords(st_reg.nbytes));
						st_next.total = 6'(dwords(st_reg.nbytes) << 2);
					end else begin
						out_byte = pbyte(DC_FIXED);
						st_next.total = 6'(DC_FIXED << 2);
					end
					st_next.cs = st_reg.cs + out_byte;
					st_next.pos = '0;
					st_next.state = ST_ID1;
				end
				ST_ID1: begin
					// R16: odd parity, field, line bits 8..3
					emit = 1'b1;
					out_byte = {oddp({st_reg.txt.field_identifier, st_reg.txt.line[8:3]}),
						st_reg.txt.field_identifier, st_reg.txt.line[8:3]};
					st_next.cs = st_reg.cs + out_byte;
					st_next.pos = st_reg.pos + 1'b1;
					st_next.state = ST_ID2;
				end
				ST_ID2: begin
					// R16: odd parity, line bits 2..0, data type
					emit = 1'b1;
					out_byte = {oddp({st_reg.txt.line[2:0], st_reg.txt.dtype}),
						st_reg.txt.line[2:0], st_reg.txt.dtype};
					st_next.cs = st_reg.cs + out_byte;
					st_next.pos = st_reg.pos + 1'b1;
					st_next.state = ST_DATA;
				end
				ST_DATA: begin
					// R17: fill past the text bytes
					if (st_reg.pos >= text_lim) begin
						emit = 1'b1;
						out_byte = FILL_BYTE;
					end else if (txt_valid) begin
						emit = 1'b1;
						out_byte = txt_data;
					end
					if (emit) begin
						// R18: accumulate through last data byte
						st_next.cs = st_reg.cs + out_byte;
						st_next.pos = st_reg.pos + 1'b1;
						if (st_reg.pos == st_reg.total - 1'b1) begin
							st_next.state = ST_CS;
						end
					end
				end
				ST_CS: begin
					emit = 1'b1;
					out_byte = {st_reg.cs[6], st_reg.cs[6:0]};
					st_next.state = ST_BC;
				end
				ST_BC: begin
					// R19: valid count with odd parity
					emit = 1'b1;
					out_byte = {oddp({1'b0, text_lim}), 1'b0, text_lim};
					st_next.kind = K_TEAV;
					st_next.state = (st_reg.anc || st_reg.cfg.ctrl.code_off) ?
						ST_IDLE : ST_PRE;
				end
				default: begin
					st_next.state = ST_IDLE;
				end
			endcase
		end
		// R2: R10: invalid cycles carry 00 with qualifier low
		st_next.dout = emit ? out_byte : IDLE_BYTE;
		st_next.qual = emit;
		// R1: gate levels or single trigger pulses on rising edges
		if (st_reg.cfg.ctrl.trig) begin
			hsrc = st_next.hgate && !st_reg.hgate;
			vsrc = st_next.vgate && st_next.hgate && !st_reg.hgate;
		end else begin
			hsrc = st_next.hgate;
			vsrc = st_next.vgate && st_next.hgate;
		end
		src_vec = {!adv, st_next.sliced, st_next.vf, vsrc, hsrc,
			st_next.qual};
		// R5: pin mapping and polarity
		for (int i = 0; i < 5; i++) begin
			st_next.pins[i] = st_reg.cfg.pol[i] ^
				((st_reg.cfg.map[3*i +: 3] <= SRC_HOLD) ?
				src_vec[st_reg.cfg.map[3*i +: 3]] : 1'b0);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			st_reg <= '0;
			st_reg.cfg <= CFG_RESET;
		end else begin
			st_reg <= st_next;
		end
	end

	assign reg_rdata = st_reg.rdata;
	assign port_data = st_reg.dout;
	assign output_data_qualifier_pin = st_reg.pins[0];
	assign horizontal_reference_pin = st_reg.pins[1];
	assign vertical_reference_pin = st_reg.pins[2];
	assign general_output_pin_a = st_reg.pins[3];
	assign general_output_pin_b = st_reg.pins[4];

	idle_zero_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R2
		!st_reg.qual |-> st_reg.dout == 8'h00)
		else $error("invalid cycle not 00");
	hold_stall_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R4
		!adv |=> !st_reg.qual && $stable(st_reg.state))
		else $error("output moved while held");
	trig_pulse_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R1
		st_reg.cfg.ctrl.trig && $stable(st_reg.cfg) && st_reg.pins[1] &&
		!st_reg.cfg.pol[1] && st_reg.cfg.map[5:3] == 3'h1 |=> !st_reg.pins[1])
		else $error("trigger pulse longer than one cycle");
	pre_ff_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R11
		st_reg.state == ST_PRE && !st_reg.anc && st_reg.idx == 2'h0 && adv
		|=> st_reg.dout == 8'hFF ##1 st_reg.state == ST_PRE)
		else $error("preamble does not open with FF");
	sav_code_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R6
		st_reg.state == ST_CODE && st_reg.kind == K_VSAV && adv && st_reg.vmsb
		&& !st_reg.vv && !st_reg.vf |=> st_reg.dout == 8'h80 && st_reg.qual)
		else $error("wrong start code");
	dc_fixed_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
		st_reg.state == ST_DC && !st_reg.anc && adv |=> st_reg.dout == 8'h4B)
		else $error("fixed count byte not 4B");
	src_parity_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R13
		st_reg.state == ST_SOURCE_ID_BYTE && adv |=> st_reg.dout[7] != st_reg.dout[6] &&
		st_reg.dout[6] == ^st_reg.dout[5:0])
		else $error("source id parity wrong");
	fill_byte_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R17
		st_reg.state == ST_DATA && adv && st_reg.pos >= text_lim
		|=> st_reg.dout == 8'hA0)
		else $error("fill byte not A0");
	count_par_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R19
		st_reg.state == ST_BC && adv |=> ^st_reg.dout && !st_reg.dout[6])
		else $error("valid count byte malformed");
	sliced_clr_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R24
		st_reg.state == ST_CODE && st_reg.kind == K_VSAV && adv
		|=> !st_reg.sliced)
		else $error("sliced flag kept past start code");
endmodule
`default_nettype wire

// [tb/ipsc_capture.sv]
// receiving side model: hold gate source and byte capture
`timescale 1ns/1ps
`default_nettype none
module ipsc_capture (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [7:0] port_data,
	input wire logic qual_pin,
	input wire logic hold_mode,
	output logic hold_gate,
	output logic cap_valid,
	output logic [7:0] cap_byte
);
	logic [3:0] tick;
	initial begin
		hold_gate = 1'b1;
		tick = 4'h0;
		cap_valid = 1'b0;
		cap_byte = 8'h00;
	end
	always @(posedge ref_clk) begin
		tick <= resetn ? tick + 4'h1 : 4'h0;
		hold_gate <= !hold_mode || tick == 4'hF;
	end
	always @(posedge ref_clk) begin
		cap_valid <= resetn && qual_pin === 1'b1;
		cap_byte <= port_data;
	end
endmodule
`default_nettype wire

// [tb/tb_image_port_stream_coder.sv]
// self-checking bench for the image port stream coder
`timescale 1ns/1ps
`default_nettype none
module tb_image_port_stream_coder;
	import ipsc_pkg::*;
	localparam int BL = 4;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic vid_valid = 1'b0;
	ipsc_vid_type vid_in = '0;
	logic txt_req = 1'b0;
	ipsc_txt_type txt_info = '0;
	logic txt_valid = 1'b0;
	logic [7:0] txt_data = 8'h00;
	logic vid_ready, txt_ack, txt_ready, hold, qual, hpin, vpin, pin_a, pin_b;
	logic [7:0] port_data, cap_byte;
	logic hold_mode = 1'b0;
	logic cap_valid, hq, vq;
	logic [10:0] exp_q[$];
	logic [10:0] e;
	logic [5:0] src_id = 6'h00;
	logic trig_on = 1'b0;
	int err_total = 0;
	int compares = 0;
	int run = 0;
	logic [7:0] ctab [16] = '{8'h0E, 8'h49, 8'h13, 8'h54, 8'h25, 8'h62,
		8'h38, 8'h7F, 8'h80, 8'hC7, 8'h9D, 8'hDA, 8'hAB, 8'hEC, 8'hB6, 8'hF1};
	always #12.5 ref_clk = ~ref_clk;
	ipsc_coder #(.BURST_LEN(8'h04)) dut_u (.ref_clk(ref_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .vid_valid(vid_valid),
		.vid_in(vid_in), .vid_ready(vid_ready), .txt_req(txt_req),
		.txt_info(txt_info), .txt_ack(txt_ack), .txt_valid(txt_valid),
		.txt_data(txt_data), .txt_ready(txt_ready),
		.output_hold_gate_input(hold), .port_data(port_data),
		.output_data_qualifier_pin(qual), .horizontal_reference_pin(hpin),
		.vertical_reference_pin(vpin), .general_output_pin_a(pin_a),
		.general_output_pin_b(pin_b));
	ipsc_capture far_u (.ref_clk(ref_clk), .resetn(resetn),
		.port_data(port_data), .qual_pin(qual), .hold_mode(hold_mode),
		.hold_gate(hold), .cap_valid(cap_valid), .cap_byte(cap_byte));
	task automatic final_report();
		if (err_total == 0 && compares > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] want);
		compares++;
		if (got !== want) begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, got, want);
		end
	endtask
	function automatic logic [7:0] pe(input logic [5:0] x);
		return {~(^x), ^x, x};
	endfunction
	function automatic logic [7:0] po(input logic [6:0] x);
		return {~(^x), x};
	endfunction
	function automatic logic [7:0] timing_code_byte(input logic f, input logic v,
		input logic h);
		return {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
		d = reg_rdata;
	endtask
	task automatic code(input logic [7:0] c);
		exp_q.push_back({3'b000, PRE_FF});
		exp_q.push_back({3'b000, PRE_ZERO});
		exp_q.push_back({3'b000, PRE_ZERO});
		exp_q.push_back({3'b000, c});
	endtask
	task automatic drain();
		for (int k = 0; k < 900 && exp_q.size() != 0; k++) @(posedge ref_clk);
		repeat (4) @(posedge ref_clk);
	endtask
	task automatic line(input logic f, input int t, input logic tb_,
		input logic m, input logic cd, input int np);
		ipsc_vid_type v;
		logic ok;
		v = '0;
		v.field_identifier = f;
		v.vblank = (t == 2);
		v.last_active = (t == 1);
		v.task_b = tb_;
		if (cd) code(ctab[{m, v.vblank, 1'b0, f}]);
		// trigger pulses ride on the start code
		if (cd && trig_on) exp_q[$][10:8] = {2'b11, !v.vblank};
		for (int k = 0; k < np; k++) begin
			v.data = 8'($urandom);
			v.first = (k == 0);
			v.last = (k == np - 1);
			exp_q.push_back({1'b1, !trig_on, !v.vblank && !trig_on, v.data});
			vid_valid <= 1'b1;
			vid_in <= v;
			do begin
				@(negedge ref_clk);
				ok = vid_ready;
				@(posedge ref_clk);
			end while (ok !== 1'b1);
		end
		vid_valid <= 1'b0;
		if (cd) code(ctab[{m, t != 0, 1'b1, f}]);
		drain();
	endtask
	task automatic text(input logic [5:0] sel, input logic [8:0] ln,
		input int n);
		ipsc_txt_type ti;
		logic [7:0] b[$];
		logic [7:0] d[$];
		logic [7:0] cs;
		logic [1:0] rg;
		logic tc, ok;
		int tot;
		ti = '0;
		ti.line = ln;
		ti.dtype = 4'($urandom);
		ti.count = 6'(n);
		ti.field_identifier = 1'($urandom);
		ti.vblank = 1'b1;
		tc = (sel >= SEL_MSB_SET);
		rg = ln == 0 ? 2'b00 : ln <= 23 ? 2'b01 : ln == 24 ? 2'b10 : 2'b11;
		for (int k = 0; k < n; k++) d.push_back(8'($urandom));
		if (tc) b.push_back(timing_code_byte(ti.field_identifier, 1'b1, 1'b0) & {sel == SEL_MSB_SET, 7'h7F});
		else b.push_back(pe(sel == 0 ? {3'b010, ti.field_identifier, rg} : sel));
		b.push_back(pe(src_id));
		tot = tc ? 44 : 4 * ((n + 5) / 4);
		b.push_back(tc ? 8'h4B : pe(6'(tot / 4)));
		b.push_back(po({ti.field_identifier, ln[8:3]}));
		b.push_back(po({ln[2:0], ti.dtype}));
		b = {b, d};
		while (b.size() < tot + 3) b.push_back(8'hA0);
		cs = 8'h00;
		foreach (b[k]) cs = cs + b[k];
		b.push_back({cs[6], cs[6:0]});
		b.push_back(po({1'b0, 6'(n + 2)}));
		exp_q.push_back({3'b000, tc ? PRE_FF : PRE_ZERO});
		exp_q.push_back({3'b000, tc ? PRE_ZERO : PRE_FF});
		exp_q.push_back({3'b000, tc ? PRE_ZERO : PRE_FF});
		foreach (b[k]) exp_q.push_back({3'b000, b[k]});
		if (tc) code(timing_code_byte(ti.field_identifier, 1'b1, 1'b1) & {sel == SEL_MSB_SET, 7'h7F});
		txt_req <= 1'b1;
		txt_info <= ti;
		do begin
			@(negedge ref_clk);
			ok = txt_ack;
			@(posedge ref_clk);
		end while (ok !== 1'b1);
		txt_req <= 1'b0;
		foreach (d[k]) begin
			txt_valid <= 1'b1;
			txt_data <= d[k];
			do begin
				@(negedge ref_clk);
				ok = txt_ready;
				@(posedge ref_clk);
			end while (ok !== 1'b1);
		end
		txt_valid <= 1'b0;
		drain();
	endtask
	always @(posedge ref_clk) begin
		hq <= hpin;
		vq <= vpin;
		run = cap_valid ? run + 1 : 0;
		if (resetn && qual !== 1'b1) chk(32'(port_data), 0);
		if (cap_valid) begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
			chk(32'(cap_byte), 32'(e[7:0]));
			if (e[10]) chk(32'({hq, vq}), 32'(e[9:8]));
			if (hold_mode && run > BL) chk(run, BL);
		end
	end
	initial begin
		logic [31:0] r;
		void'($urandom(32'hd50aa2b5));
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rd(ADDR_HDR, r);
		chk(r, 32'h3E);
		rd(ADDR_MAP, r);
		chk(r, 32'h3888);
		rd(8'h40, r);
		chk(r, 32'h0);
		src_id = 6'($urandom);
		wr(ADDR_SRC, 32'(src_id));
		rd(ADDR_SRC, r);
		chk(r, 32'(src_id));
		chk(32'({hpin, vpin, pin_a, pin_b}), 32'h0);
		wr(ADDR_POL, 32'h1E);
		repeat (3) @(posedge ref_clk);
		chk(32'({qual, hpin, vpin, pin_a, pin_b}), 32'h0F);
		wr(ADDR_POL, 32'h0);
		wr(ADDR_CTRL, 32'h04);
		for (int i = 0; i < 12; i++) line(i[0], (i / 2) % 3, i >= 6, i >= 6, 1, 3);
		wr(ADDR_CTRL, 32'h06);
		trig_on = 1'b1;
		line(1'b0, 0, 1'b0, 1'b0, 1'b1, 3);
		trig_on = 1'b0;
		wr(ADDR_CTRL, 32'h05);
		line(1'b0, 0, 1'b0, 1'b1, 1'b0, 3);
		wr(ADDR_CTRL, 32'h00);
		text(SEL_MSB_SET, 9'd14, 5);
		chk(32'(pin_a), 32'h1);
		line(1'b1, 2, 1'b0, 1'b1, 1'b1, 2);
		chk(32'(pin_a), 32'h0);
		wr(ADDR_HDR, 32'h0);
		for (int i = 0; i < 4; i++) text(6'h00, 9'(i == 3 ? 30 : i * 12), 1 + i * 2);
		wr(ADDR_HDR, 32'h15);
		text(6'h15, 9'd5, 4);
		wr(ADDR_HDR, 32'h3F);
		wr(ADDR_CTRL, 32'h10);
		hold_mode <= 1'b1;
		line(1'b0, 0, 1'b0, 1'b1, 1'b1, 12);
		text(SEL_MSB_CLR, 9'd7, 4);
		hold_mode <= 1'b0;
		chk(32'(exp_q.size()), 32'h0);
		final_report();
	end
	initial begin
		repeat (40000) @(posedge ref_clk);
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
